// ### bgd_guard.sv
// Boot flash access guard: gates flash stores, loads, fetches and
// interrupts by section and lock bits, and halts the CPU when needed.
// Assumes one clock, an AHB-Lite master and a flash that ends each
// erase or write with a done pulse and returns read data in the same
// cycle as its read strobe.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "bgd_map.svh"

module bgd_guard import bgd_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// CPU side
	input wire logic [12:0] exec_addr_i,
	input wire logic flash_store_instr_i,
	input wire logic [1:0] store_op_i,
	input wire logic [12:0] store_addr_i,
	input wire logic [15:0] store_data_i,
	input wire logic rd_req_i,
	input wire logic rd_is_load_i,
	input wire logic [12:0] rd_addr_i,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	input wire logic irq_req_i,
	output logic irq_o,
	output logic cpu_halt_o,
	// Programmer interface and chip erase
	input wire logic prog_lock_we_i,
	input wire logic [3:0] prog_lock_data_i,
	input wire logic chip_erase_i,
	// Flash array side
	output logic fl_start_o,
	output logic fl_erase_o,
	output logic fl_fill_o,
	output logic [12:0] fl_addr_o,
	output logic [15:0] fl_wdata_o,
	input wire logic fl_done_i,
	output logic fl_rd_o,
	output logic [12:0] fl_rd_addr_o,
	input wire logic [7:0] fl_rd_data_i
);
	// ==========================================================
	// Lock decode
	logic [3:0] lock;
	logic exec_boot;
	logic vec_boot;
	logic app_store_ok;
	logic boot_store_ok;
	logic app_load_ok;
	logic boot_load_ok;
	logic irq_block;

	assign exec_boot = bgd_in_boot(exec_addr_i);

	bgd_lock_decode u_decode (
		.lock_i(lock),
		.exec_boot_i(exec_boot),
		.vec_boot_i(vec_boot),
		.app_store_ok_o(app_store_ok),
		.boot_store_ok_o(boot_store_ok),
		.app_load_ok_o(app_load_ok),
		.boot_load_ok_o(boot_load_ok),
		.irq_block_o(irq_block)
	);

	// ==========================================================
	// Bus slave, zero wait states
	logic wr_pend;
	logic [11:0] wr_addr;
	logic reenable;
	logic section_busy_flag;
	logic next_wr_pend;
	logic [11:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic next_vec_boot;
	logic next_reenable;
	logic acc;

	assign acc = hsel && hready && htrans[1];

	always_comb begin
		next_wr_pend = acc && hwrite;
		next_wr_addr = acc ? haddr : wr_addr;
		next_vec_boot = vec_boot;
		next_reenable = 1'b0;
		next_hrdata = 32'h0000_0000;
		if (wr_pend && wr_addr == `BGD_CTRL_OFS) begin
			next_vec_boot = hwdata[`BGD_CTRL_VEC_BOOT];
			next_reenable = hwdata[`BGD_CTRL_REENABLE];
		end
		if (acc && !hwrite) begin
			case (haddr)
				`BGD_CTRL_OFS: next_hrdata[`BGD_CTRL_VEC_BOOT] = vec_boot;
				`BGD_STATUS_OFS: begin
					next_hrdata[`BGD_STAT_BUSY] = section_busy_flag;
					next_hrdata[`BGD_STAT_ACTIVE] = fl_erase_o || fl_start_o
						|| cpu_halt_o || section_busy_flag;
					next_hrdata[`BGD_STAT_HALT] = cpu_halt_o;
				end
				`BGD_LOCK_OFS: next_hrdata[3:0] = lock;
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			vec_boot <= `BGD_CTRL_RST;
			reenable <= 1'b0;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			vec_boot <= next_vec_boot;
			reenable <= next_reenable;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// Store handling and programming sequencer
	bgd_state_e state;
	bgd_state_e next_state;
	logic [3:0] next_lock;
	logic next_busy;
	logic next_start;
	logic next_erase;
	logic next_fill;
	logic [12:0] next_fl_addr;
	logic [15:0] next_wdata;
	logic st_ok;
	logic tgt_boot;

	assign tgt_boot = bgd_in_boot(store_addr_i);
	assign st_ok = tgt_boot ? boot_store_ok : app_store_ok;

	always_comb begin
		next_state = state;
		next_lock = lock;
		next_busy = section_busy_flag;
		next_start = 1'b0;
		next_erase = fl_erase_o;
		next_fill = 1'b0;
		next_fl_addr = fl_addr_o;
		next_wdata = fl_wdata_o;
		case (state)
			BGD_IDLE: begin
				if (reenable)
					next_busy = 1'b0;
				// General lock modes are not inputs here on purpose
				if (flash_store_instr_i && exec_boot
					&& (st_ok || store_op_i == BGD_OP_LOCKSET)) begin
					case (store_op_i)
						BGD_OP_FILL: begin
							next_fill = 1'b1;
							next_fl_addr = store_addr_i;
							next_wdata = store_data_i;
							next_busy = 1'b0;
						end
						BGD_OP_LOCKSET:
							next_lock = lock & store_data_i[3:0];
						default: begin
							next_start = 1'b1;
							next_erase = (store_op_i == BGD_OP_ERASE);
							next_fl_addr = store_addr_i;
							if (bgd_in_stalling_section(store_addr_i)) begin
								next_state = BGD_BUSY_STALLING_SECTION;
							end else begin
								next_state = BGD_BUSY_RWW;
								next_busy = 1'b1;
							end
						end
					endcase
				end
			end
			BGD_BUSY_RWW, BGD_BUSY_STALLING_SECTION: begin
				if (fl_done_i) begin
					next_state = BGD_IDLE;
					next_erase = 1'b0;
				end
			end
			default: next_state = BGD_IDLE;
		endcase
		if (prog_lock_we_i)
			next_lock = next_lock & prog_lock_data_i;
		if (chip_erase_i)
			next_lock = `BGD_LOCK_RST;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= BGD_IDLE;
			lock <= `BGD_LOCK_RST;
			section_busy_flag <= 1'b0;
			fl_start_o <= 1'b0;
			fl_erase_o <= 1'b0;
			fl_fill_o <= 1'b0;
			fl_addr_o <= 13'h0000;
			fl_wdata_o <= 16'h0000;
			cpu_halt_o <= 1'b0;
		end else begin
			state <= next_state;
			lock <= next_lock;
			section_busy_flag <= next_busy;
			fl_start_o <= next_start;
			fl_erase_o <= next_erase;
			fl_fill_o <= next_fill;
			fl_addr_o <= next_fl_addr;
			fl_wdata_o <= next_wdata;
			cpu_halt_o <= (next_state == BGD_BUSY_STALLING_SECTION);
		end
	end

	// ==========================================================
	// Read path: fetches and loads, two-cycle latency
	logic rd_pend;
	logic next_grant;
	logic ld_ok;

	assign ld_ok = bgd_in_boot(rd_addr_i) ? boot_load_ok : app_load_ok;

	always_comb begin
		next_grant = rd_req_i && (next_state != BGD_BUSY_STALLING_SECTION);
		// Concurrent section unreadable while blocked
		if (section_busy_flag && !bgd_in_stalling_section(rd_addr_i))
			next_grant = 1'b0;
		if (rd_is_load_i && !ld_ok)
			next_grant = 1'b0;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_pend <= 1'b0;
			fl_rd_o <= 1'b0;
			fl_rd_addr_o <= 13'h0000;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
			irq_o <= 1'b0;
		end else begin
			rd_pend <= rd_req_i;
			fl_rd_o <= next_grant;
			fl_rd_addr_o <= rd_addr_i;
			rd_valid_o <= rd_pend;
			// Refused reads give zero and no error
			rd_data_o <= fl_rd_o ? fl_rd_data_i : 8'h00;
			irq_o <= irq_req_i && !irq_block;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	logic store_go;
	assign store_go = flash_store_instr_i && state == BGD_IDLE && exec_boot
		&& (store_op_i == BGD_OP_ERASE || store_op_i == BGD_OP_WRITE);

	sequence stalling_section_go_s;
		store_go && st_ok && bgd_in_stalling_section(store_addr_i);
	endsequence
	sequence rww_go_s;
		store_go && st_ok && !bgd_in_stalling_section(store_addr_i);
	endsequence

	halt_on_stalling_section_a: assert property (stalling_section_go_s |=> cpu_halt_o && fl_start_o
		&& !fl_rd_o)
		else $error("no halt for stalling-section programming");
	rww_no_halt_a: assert property (rww_go_s |=> !cpu_halt_o
		&& section_busy_flag && fl_start_o)
		else $error("concurrent-section programming halted the CPU");
	halt_read_a: assert property (cpu_halt_o |-> !fl_rd_o)
		else $error("flash read during halt");
	app_store_lock_a: assert property (store_go && !tgt_boot
		&& !lock[`BGD_LK_APP_WR] |=> !fl_start_o)
		else $error("locked application store started");
	boot_store_lock_a: assert property (store_go && tgt_boot
		&& !lock[`BGD_LK_BOOT_WR] |=> !fl_start_o)
		else $error("locked loader store started");
	app_store_ign_a: assert property (flash_store_instr_i && !exec_boot
		|=> !fl_start_o && !fl_fill_o && lock == $past(lock))
		else $error("store from application acted");
	load_refuse_a: assert property (rd_req_i && rd_is_load_i && exec_boot
		&& !bgd_in_boot(rd_addr_i) && !lock[`BGD_LK_APP_RD]
		|=> !fl_rd_o ##1 rd_valid_o && rd_data_o == 8'h00)
		else $error("locked application load served");
	boot_load_ref_a: assert property (rd_req_i && rd_is_load_i && !exec_boot
		&& bgd_in_boot(rd_addr_i) && !lock[`BGD_LK_BOOT_RD]
		|=> !fl_rd_o ##1 rd_data_o == 8'h00)
		else $error("locked loader load served");
	lock_clear_a: assert property ((lock & ~$past(lock)) != 4'h0
		|-> $past(chip_erase_i))
		else $error("lock bit cleared without chip erase");
	irq_mask_a: assert property (irq_req_i && vec_boot && !exec_boot
		&& !lock[`BGD_LK_APP_RD] |=> !irq_o)
		else $error("interrupt passed in locked application");
	open_lock_a: assert property (lock == `BGD_LOCK_RST && rd_req_i
		&& rd_is_load_i && !section_busy_flag && state == BGD_IDLE
		|=> fl_rd_o)
		else $error("load refused with no lock programmed");

endmodule : bgd_guard
`default_nettype wire

// ### bgd_map.svh
// Constants for the boot flash access guard: register offsets,
// field positions, reset values and section limits.
// Assumes a flash of 8K bytes addressed by 13-bit byte addresses.
`ifndef BGD_MAP_SVH
`define BGD_MAP_SVH

// ==========================================================
// Register offsets (byte addresses on the bus)
`define BGD_CTRL_OFS 12'h000
`define BGD_STATUS_OFS 12'h004
`define BGD_LOCK_OFS 12'h008

// ==========================================================
// Field positions
`define BGD_CTRL_VEC_BOOT 0
`define BGD_CTRL_REENABLE 1
`define BGD_STAT_BUSY 0
`define BGD_STAT_ACTIVE 1
`define BGD_STAT_HALT 2
`define BGD_LK_APP_WR 0
`define BGD_LK_APP_RD 1
`define BGD_LK_BOOT_WR 2
`define BGD_LK_BOOT_RD 3

// ==========================================================
// Reset values; lock bits read 1 when unprogrammed
`define BGD_LOCK_RST 4'hf
`define BGD_CTRL_RST 1'b0

// ==========================================================
// Section limits
`define BGD_ADDR_W 13
`define BGD_BOOT_START 13'h1c00
`define BGD_STALLING_SECTION_START 13'h1800

`endif

// ### bgd_pkg.sv
// Types and section decoding for the boot flash access guard.
// Assumes bgd_map.svh is on the include path.
`include "bgd_map.svh"

package bgd_pkg;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		BGD_OP_FILL,
		BGD_OP_ERASE,
		BGD_OP_WRITE,
		BGD_OP_LOCKSET
	} bgd_op_e;

	typedef enum logic [1:0] {
		BGD_IDLE,
		BGD_BUSY_RWW,
		BGD_BUSY_STALLING_SECTION
	} bgd_state_e;

	typedef logic [`BGD_ADDR_W-1:0] bgd_addr_t;

	// ==========================================================
	// Section decoding
	function automatic logic bgd_in_boot(input bgd_addr_t a);
		return a >= `BGD_BOOT_START;
	endfunction : bgd_in_boot

	function automatic logic bgd_in_stalling_section(input bgd_addr_t a);
		return a >= `BGD_STALLING_SECTION_START;
	endfunction : bgd_in_stalling_section

endpackage : bgd_pkg

// ### bgd_lock_decode.sv
// Decodes the two lock fields into store, load and interrupt permits.
// Purely combinational; the caller registers whatever leaves the block.
`timescale 1ns/1ns
`default_nettype none
`include "bgd_map.svh"

module bgd_lock_decode import bgd_pkg::*; (
	input wire logic [3:0] lock_i,
	input wire logic exec_boot_i,
	input wire logic vec_boot_i,
	output logic app_store_ok_o,
	output logic boot_store_ok_o,
	output logic app_load_ok_o,
	output logic boot_load_ok_o,
	output logic irq_block_o
);
	logic app_write_lock_bit;
	logic app_read_lock_bit;
	logic boot_write_lock_bit;
	logic boot_read_lock_bit;

	assign app_write_lock_bit = lock_i[`BGD_LK_APP_WR];
	assign app_read_lock_bit = lock_i[`BGD_LK_APP_RD];
	assign boot_write_lock_bit = lock_i[`BGD_LK_BOOT_WR];
	assign boot_read_lock_bit = lock_i[`BGD_LK_BOOT_RD];

	// ==========================================================
	// Permits; a zero bit is programmed
	assign app_store_ok_o = app_write_lock_bit;
	assign boot_store_ok_o = boot_write_lock_bit;
	// Same-section loads are never restricted
	assign app_load_ok_o = app_read_lock_bit || !exec_boot_i;
	assign boot_load_ok_o = boot_read_lock_bit || exec_boot_i;
	assign irq_block_o =
		(!app_read_lock_bit && vec_boot_i && !exec_boot_i) ||
		(!boot_read_lock_bit && !vec_boot_i && exec_boot_i);

endmodule : bgd_lock_decode

`default_nettype wire

// ### bgd_flash_model.sv
// Flash array stand-in for the access guard bench.
// Assumes one clock; erase or write takes 3 or 40 cycles by slow_i.
`timescale 1ns/1ns
`default_nettype none

module bgd_flash_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	input wire logic fl_start_i,
	input wire logic fl_rd_i,
	input wire logic [12:0] fl_rd_addr_i,
	output logic fl_done_o,
	output logic [7:0] fl_rd_data_o
);
	int cnt;
	logic hold;
	logic [12:0] last;
	logic [7:0] noise;

	// ==========================================================
	// Program timing and read hold
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 0;
			fl_done_o <= 1'b0;
			noise <= 8'h00;
			hold <= 1'b0;
			last <= 13'h0000;
		end else begin
			noise <= noise + 8'h3b;
			fl_done_o <= (cnt == 1);
			hold <= fl_rd_i;
			last <= fl_rd_addr_i;
			if (fl_start_i)
				cnt <= slow_i ? 40 : 3;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end

	// For one cycle after a read the bus holds the last read data, then shows a moving pattern
	assign fl_rd_data_o = fl_rd_i ? fl_rd_addr_i[7:0] ^ 8'ha5 :
		hold ? last[7:0] ^ 8'ha5 : noise;
endmodule : bgd_flash_model
`default_nettype wire

// ### boot_flash_access_guard_tb.sv
// Self-checking bench for the boot flash access guard.
// Assumes bgd_map.svh, bgd_pkg and bgd_flash_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "bgd_map.svh"

module boot_flash_access_guard_tb;
	import bgd_pkg::*;
	localparam logic [12:0] bs = `BGD_BOOT_START;
	localparam logic [12:0] ns = `BGD_STALLING_SECTION_START;
	logic clk_sys_i = 0, rst_n_i = 0, hsel = 0, hwrite = 0, slow = 0;
	logic [11:0] haddr = 0;
	logic [1:0] htrans = 0, store_op_i = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 0, hrdata, v;
	logic hreadyout, hresp, rd_valid_o, irq_o, cpu_halt_o, fl_done_i;
	logic flash_store_instr_i = 0, rd_req_i = 0, rd_is_load_i = 0;
	logic irq_req_i = 0, prog_lock_we_i = 0, chip_erase_i = 0;
	logic [12:0] exec_addr_i = 0, store_addr_i = 0, rd_addr_i = 0;
	logic [15:0] store_data_i = 0, fl_wdata_o;
	logic [3:0] prog_lock_data_i = 0;
	logic [7:0] rd_data_o, fl_rd_data_i, rnd = 8'h44;
	logic fl_start_o, fl_erase_o, fl_fill_o, fl_rd_o;
	logic [12:0] fl_addr_o, fl_rd_addr_o;
	int num_errors = 0, comparisons = 0, cyc = 0;
	int lock = 15, busy = 0, hlt = 0, act = 0, vec = 0;
	int ops = 0, dones = 0;

	bgd_guard i_bgd_guard (.clk_sys_i, .rst_n_i, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .exec_addr_i, .flash_store_instr_i, .store_op_i,
		.store_addr_i, .store_data_i, .rd_req_i, .rd_is_load_i, .rd_addr_i,
		.rd_valid_o, .rd_data_o, .irq_req_i, .irq_o, .cpu_halt_o,
		.prog_lock_we_i, .prog_lock_data_i, .chip_erase_i, .fl_start_o,
		.fl_erase_o, .fl_fill_o, .fl_addr_o, .fl_wdata_o, .fl_done_i,
		.fl_rd_o, .fl_rd_addr_o, .fl_rd_data_i);
	bgd_flash_model i_bgd_flash_model (.clk_sys_i, .rst_n_i, .slow_i(slow),
		.fl_start_i(fl_start_o), .fl_rd_i(fl_rd_o),
		.fl_rd_addr_i(fl_rd_addr_o), .fl_done_o(fl_done_i),
		.fl_rd_data_o(fl_rd_data_i));

	always #5 clk_sys_i = ~clk_sys_i;

	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			final_report();
		end
	end

	// Counts finished operations seen from the flash side
	always @(posedge clk_sys_i)
		if (fl_done_i === 1'b1)
			dones <= dones + 1;

	// ==========================================================
	// Bus, store, read and interrupt tasks
	task automatic ahb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk_sys_i);
		while (hreadyout !== 1'b1) @(posedge clk_sys_i);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk_sys_i);
		while (hreadyout !== 1'b1) @(posedge clk_sys_i);
		v = hrdata;
		check(hresp, 1'b0);
	endtask : ahb

	task automatic st(input logic [1:0] o, input logic [12:0] a,
		input logic [15:0] d, input logic [12:0] e);
		int ok;
		ok = !act && e >= bs;
		if (o != 3 && a < bs && !lock[0]) ok = 0;
		if (o != 3 && a >= bs && !lock[2]) ok = 0;
		@(posedge clk_sys_i);
		flash_store_instr_i <= 1'b1;
		store_op_i <= o;
		store_addr_i <= a;
		store_data_i <= d;
		exec_addr_i <= e;
		@(posedge clk_sys_i);
		flash_store_instr_i <= 1'b0;
		#1;
		if (ok && o == 3) lock &= d;
		if (ok && o == 0) busy = 0;
		if (ok && (o == 1 || o == 2)) begin
			act = 1;
			ops++;
			hlt = a >= ns;
			busy = busy || a < ns;
		end
		check(fl_fill_o, ok && o == 0);
		check(fl_start_o, ok && (o == 1 || o == 2));
		check(fl_erase_o, ok && o == 1);
		if (ok && o != 3) check(fl_addr_o, a);
		if (ok && o == 0) check(fl_wdata_o, d);
		check(cpu_halt_o, hlt);
	endtask : st

	task automatic fin;
		for (int i = 0; i < 100 && dones < ops; i++)
			@(posedge clk_sys_i);
		check(dones, ops);
		@(posedge clk_sys_i);
		#1;
		act = 0;
		hlt = 0;
		check(cpu_halt_o, 1'b0);
		check(fl_erase_o, 1'b0);
	endtask : fin

	task automatic rd(input logic [12:0] a, input logic ld,
		input logic [12:0] e);
		int ok;
		ok = !hlt && !(busy && a < ns);
		if (ld && e >= bs && a < bs && !lock[1]) ok = 0;
		if (ld && e < bs && a >= bs && !lock[3]) ok = 0;
		@(posedge clk_sys_i);
		rd_req_i <= 1'b1;
		rd_is_load_i <= ld;
		rd_addr_i <= a;
		exec_addr_i <= e;
		@(posedge clk_sys_i);
		rd_req_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		check(rd_valid_o, 1'b1);
		check(rd_data_o, ok ? a[7:0] ^ 8'ha5 : 8'h00);
	endtask : rd

	task automatic irqchk(input logic [12:0] e);
		int m;
		rnd = lfsr(rnd);
		m = (vec && e < bs && !lock[1]) || (!vec && e >= bs && !lock[3]);
		@(posedge clk_sys_i);
		exec_addr_i <= e;
		irq_req_i <= rnd[0];
		repeat (2) @(posedge clk_sys_i);
		#1;
		check(irq_o, rnd[0] && !m);
	endtask : irqchk

	task automatic prog(input logic er, input logic [3:0] d);
		@(posedge clk_sys_i);
		chip_erase_i <= er;
		prog_lock_we_i <= !er;
		prog_lock_data_i <= d;
		@(posedge clk_sys_i);
		chip_erase_i <= 1'b0;
		prog_lock_we_i <= 1'b0;
		lock = er ? 15 : lock & d;
	endtask : prog

	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		ahb(0, 12'h008, 0);
		check(v, 32'hf);
		ahb(1, 12'h00c, 32'hffffffff);
		ahb(0, 12'h00c, 0);
		check(v, 32'h0);
		ahb(1, 12'h000, 32'h3);
		ahb(0, 12'h000, 0);
		check(v, 32'h1);
		$display("test registers done");
		st(1, 13'h0100, 0, 13'h0200);
		st(1, 13'h0100, 0, 13'h1c10);
		rd(13'h1c20, 0, 13'h1c10);
		rd(13'h0120, 1, 13'h1c10);
		ahb(0, 12'h004, 0);
		check(v[0], 1'b1);
		fin();
		rd(13'h0120, 0, 13'h1c10);
		ahb(1, 12'h000, 32'h2);
		busy = 0;
		vec = 0;
		rd(13'h0120, 0, 13'h1c10);
		$display("test concurrent section done");
		slow <= 1'b1;
		st(2, 13'h1900, 0, 13'h1c10);
		rd(13'h1c20, 0, 13'h1c10);
		st(0, 13'h1900, 16'h1234, 13'h1c10);
		ahb(0, 12'h004, 0);
		check(v[2], 1'b1);
		check(v[1], 1'b1);
		fin();
		slow <= 1'b0;
		$display("test stalling section done");
		for (int m = 0; m < 16; m++) begin
			prog(1, 0);
			st(3, 0, m, 13'h1c10);
			ahb(0, 12'h008, 0);
			check(v, lock);
			rnd = lfsr(rnd);
			st(0, 13'h0040, {rnd, rnd}, 13'h1c10);
			st(0, 13'h1c40, {rnd, rnd}, 13'h1c10);
			rd(13'h0040, 1, 13'h1c10);
			rd(13'h1c40, 1, 13'h0040);
			rd(13'h1c40, 1, 13'h1c10);
			st(1, 13'h1900, 0, 13'h1c10);
			fin();
			st(2, 13'h1c40, 0, 13'h1c10);
			fin();
			for (int b = 0; b < 2; b++) begin
				ahb(1, 12'h000, b);
				vec = b;
				irqchk(13'h0040);
				irqchk(13'h1c40);
			end
		end
		$display("test lock modes done");
		prog(1, 0);
		rnd = lfsr(rnd);
		prog(0, rnd[3:0]);
		prog(0, rnd[7:4]);
		ahb(0, 12'h008, 0);
		check(v, lock);
		prog(1, 0);
		ahb(0, 12'h008, 0);
		check(v, 32'hf);
		$display("test programmer path done");
		final_report();
	end
endmodule : boot_flash_access_guard_tb
`default_nettype wire
